// *** oneshot_pwt_pkg.sv ***
`default_nettype none
package oneshot_pwt_pkg;
  localparam int          DW           = 16;
  localparam int          AW           = 4;
  localparam logic [3:0]  ADDR_MODE    = 4'h0;
  localparam logic [3:0]  ADDR_CAPCTL  = 4'h1;
  localparam logic [3:0]  ADDR_OUTCTL  = 4'h2;
  localparam logic [3:0]  ADDR_EDGE    = 4'h3;
  localparam logic [3:0]  ADDR_COUNT   = 4'h4;
  localparam logic [3:0]  ADDR_CCA     = 4'h5;
  localparam logic [3:0]  ADDR_CCB     = 4'h6;
  localparam logic [3:0]  ADDR_IRQSTAT = 4'h7;
  localparam logic [3:0]  ADDR_IRQMASK = 4'h8;
  // Mode control: mode select in bits 3:2, overflow flag in bit 0.
  localparam int          MODE_LO_BIT  = 2;
  localparam int          MODE_HI_BIT  = 3;
  localparam int          OVF_BIT      = 0;
  localparam logic [1:0]  MODE_STOP    = 2'h0;
  localparam logic [1:0]  MODE_FREE    = 2'h1;
  localparam logic [1:0]  MODE_EDGECLR = 2'h2;
  localparam logic [1:0]  MODE_PPG     = 2'h3;
  // Output control.
  localparam int          TOE_BIT      = 0;
  localparam int          OSPE_BIT     = 5;
  localparam int          OST_BIT      = 6;
  // Capture control.
  localparam int          CCA_CAP_BIT  = 0;
  localparam int          CCA_OPP_BIT  = 1;
  localparam int          CCB_CAP_BIT  = 2;
  // Edge select: bits 1:0 input a, bits 3:2 input b.
  localparam logic [1:0]  EDGE_FALL    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;
  localparam int          IRQ_A_BIT    = 0;
  localparam int          IRQ_B_BIT    = 1;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [15:0] MAX16        = 16'hffff;
  localparam logic [1:0]  ZERO2        = 2'h0;
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// *** oneshot_pulse_width_timer.sv ***
// Implementation choices: strobed register access and the address map.
`default_nettype none
// Summary of operation
// - One-shot works in mode 01 or 10 with the one-shot enable bit set.
// - Soft trigger or valid edge on input a restarts counter, emits one pulse.
// - Counter equal to register a raises interrupt a and toggles the output.
// - Counter equal to register b raises interrupt b and toggles the output.
// - Pulse starts M+1 cycles after trigger and lasts N-M cycles.
// - Pulse generation period is M+1 cycles, duty (N+1)/(M+1).
// - Free-run: edge on a captures into b, edge on b captures into a.
// - Single-input free-run: opposite edge captures a, valid edge captures b.
// - Mode 10: opposite edge captures a; valid edge captures b, clears counter.
// - Overflow shows in mode bit 0; software checks it and clears it.
// - Free-run counter wraps after FFFFH and sets the overflow flag.
module oneshot_pulse_width_timer (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire oneshot_pwt_pkg::reg_req_t   bus_req,
  output logic [oneshot_pwt_pkg::DW-1:0]   rd_data,
  input  wire logic                        capture_input_a,
  input  wire logic                        capture_input_b,
  output logic                             timer_output_pin,
  output logic                             irq
);
  localparam int DW = oneshot_pwt_pkg::DW;

  logic [1:0]    sync1_reg;
  logic [1:0]    sync2_reg;
  logic [1:0]    prev_reg;
  logic [DW-1:0] cnt_reg;
  logic [DW-1:0] cca_reg;
  logic [DW-1:0] ccb_reg;
  logic [1:0]    mode_reg;
  logic          ovf_reg;
  logic [2:0]    capctl_reg;
  logic          toe_reg;
  logic          ospe_reg;
  logic [3:0]    edge_reg;
  logic [1:0]    stat_reg;
  logic [1:0]    mask_reg;
  logic          armed_reg;
  logic          first_reg;

  // Inputs from the pins are resynchronised before any edge logic sees them.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (srst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end else begin
          sync1_reg[gi] <= gi == 0 ? capture_input_a : capture_input_b;
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel == oneshot_pwt_pkg::EDGE_RISE) ? r :
               (sel == oneshot_pwt_pkg::EDGE_FALL) ? f :
               (sel == oneshot_pwt_pkg::EDGE_BOTH) ? (r | f) : 1'b0;
  endfunction

  // A pin edge reaches the capture logic two clocks after the pin moves and is stored on the third.
  wire [1:0] rise_w = sync2_reg & ~prev_reg;
  wire [1:0] fall_w = ~sync2_reg & prev_reg;
  wire valid_a = edge_hit(edge_reg[1:0], rise_w[0], fall_w[0]);
  wire valid_b = edge_hit(edge_reg[3:2], rise_w[1], fall_w[1]);
  // With both edges selected there is no opposite phase left to capture on.
  wire opp_a = (edge_reg[1:0] == oneshot_pwt_pkg::EDGE_RISE) ? fall_w[0] :
               (edge_reg[1:0] == oneshot_pwt_pkg::EDGE_FALL) ? rise_w[0] : 1'b0;

  wire running = mode_reg != oneshot_pwt_pkg::MODE_STOP;
  wire meas    = (mode_reg == oneshot_pwt_pkg::MODE_FREE) ||
                 (mode_reg == oneshot_pwt_pkg::MODE_EDGECLR);
  wire is_ppg  = mode_reg == oneshot_pwt_pkg::MODE_PPG;
  wire os_mode = meas && ospe_reg;

  wire wr_hit_w = bus_req.wr;
  wire wr_mode  = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_MODE;
  wire wr_cap   = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_CAPCTL;
  wire wr_out   = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_OUTCTL;
  wire wr_edge  = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_EDGE;
  wire wr_cca   = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_CCA;
  wire wr_ccb   = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_CCB;
  wire wr_stat  = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_IRQSTAT;
  wire wr_mask  = wr_hit_w && bus_req.addr == oneshot_pwt_pkg::ADDR_IRQMASK;

  wire soft_trig = wr_out && bus_req.wdata[oneshot_pwt_pkg::OST_BIT];
  wire os_trig   = os_mode && (soft_trig || valid_a);
  wire edge_clr  = (mode_reg == oneshot_pwt_pkg::MODE_EDGECLR) && valid_a;

  wire cca_is_cap = capctl_reg[oneshot_pwt_pkg::CCA_CAP_BIT];
  wire ccb_is_cap = capctl_reg[oneshot_pwt_pkg::CCB_CAP_BIT];
  wire cca_opp    = capctl_reg[oneshot_pwt_pkg::CCA_OPP_BIT];
  wire cap_b   = meas && ccb_is_cap && valid_a;
  wire cap_a   = meas && cca_is_cap && (cca_opp ? opp_a : valid_b);

  wire match_a = running && !cca_is_cap && cnt_reg == cca_reg;
  wire match_b = running && !ccb_is_cap && cnt_reg == ccb_reg;
  wire wrap    = running && cnt_reg == oneshot_pwt_pkg::MAX16;
  wire cnt_clr = os_trig || edge_clr || (is_ppg && match_a);

  // Mode 00 parks the counter at zero, so every start begins from 0000H.
  // This costs a clear on each stop but keeps measured widths free of old counts.
  wire [DW-1:0] cnt_next = !running ? oneshot_pwt_pkg::ZERO16 :
                           cnt_clr  ? oneshot_pwt_pkg::ZERO16 : DW'(cnt_reg + 1'b1);
  wire ovf_set  = wrap && !cnt_clr;
  wire ovf_next = ovf_set || (ovf_reg && !(wr_mode && !bus_req.wdata[oneshot_pwt_pkg::OVF_BIT]));

  // Interrupt a is withheld for opposite-phase captures into register a.
  wire [1:0] irq_evt  = {match_b || cap_b, match_a || (cap_a && !cca_opp)};
  wire [1:0] clr_w    = wr_stat ? bus_req.wdata[1:0] : oneshot_pwt_pkg::ZERO2;
  wire [1:0] stat_next = irq_evt | (stat_reg & ~clr_w);
  wire [1:0] mask_next = wr_mask ? bus_req.wdata[1:0] : mask_reg;

  // Toggles in one-shot only while a pulse is pending, so a wrapping counter
  // cannot produce a second pulse.
  wire tog_en   = toe_reg && (!os_mode || armed_reg);
  wire n_tog    = tog_en && (match_a ^ match_b);
  wire ppg_out  = match_a ? 1'b1 : match_b ? 1'b0 : timer_output_pin;
  wire out_next = !toe_reg ? 1'b0 :
                  is_ppg   ? ppg_out :
                  n_tog    ? ~timer_output_pin : timer_output_pin;
  wire os_match = os_mode && armed_reg && (match_a || match_b);

  function automatic logic [DW-1:0] pad(input logic [DW-1:0] v);
    pad = v;
  endfunction

  // Read data stay at zero outside the cycle after a read strobe.
  wire [DW-1:0] rd_next =
    bus_req.addr == oneshot_pwt_pkg::ADDR_MODE    ? pad({12'h000, mode_reg, 1'b0, ovf_reg}) :
    bus_req.addr == oneshot_pwt_pkg::ADDR_CAPCTL  ? pad({13'h0000, capctl_reg}) :
    bus_req.addr == oneshot_pwt_pkg::ADDR_OUTCTL  ? pad({10'h000, ospe_reg, 4'h0, toe_reg}) :
    bus_req.addr == oneshot_pwt_pkg::ADDR_EDGE    ? pad({12'h000, edge_reg}) :
    bus_req.addr == oneshot_pwt_pkg::ADDR_COUNT   ? cnt_reg :
    bus_req.addr == oneshot_pwt_pkg::ADDR_CCA     ? cca_reg :
    bus_req.addr == oneshot_pwt_pkg::ADDR_CCB     ? ccb_reg :
    bus_req.addr == oneshot_pwt_pkg::ADDR_IRQSTAT ? pad({14'h0000, stat_reg}) :
    bus_req.addr == oneshot_pwt_pkg::ADDR_IRQMASK ? pad({14'h0000, mask_reg}) :
                                                    oneshot_pwt_pkg::ZERO16;

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_reg   <= oneshot_pwt_pkg::MODE_STOP;
      capctl_reg <= 3'h0;
      toe_reg    <= 1'b0;
      ospe_reg   <= 1'b0;
      edge_reg   <= 4'h0;
      mask_reg   <= oneshot_pwt_pkg::ZERO2;
    end else begin
      if (wr_mode) begin
        mode_reg <= bus_req.wdata[oneshot_pwt_pkg::MODE_HI_BIT:oneshot_pwt_pkg::MODE_LO_BIT];
      end
      if (wr_cap) begin
        capctl_reg <= bus_req.wdata[2:0];
      end
      if (wr_out) begin
        toe_reg  <= bus_req.wdata[oneshot_pwt_pkg::TOE_BIT];
        ospe_reg <= bus_req.wdata[oneshot_pwt_pkg::OSPE_BIT];
      end
      if (wr_edge) begin
        edge_reg <= bus_req.wdata[3:0];
      end
      mask_reg <= mask_next;
    end
  end

  // A capture in the same cycle as a software write wins the register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cca_reg <= oneshot_pwt_pkg::ZERO16;
      ccb_reg <= oneshot_pwt_pkg::ZERO16;
    end else begin
      cca_reg <= cap_a ? cnt_reg : wr_cca ? bus_req.wdata : cca_reg;
      ccb_reg <= cap_b ? cnt_reg : wr_ccb ? bus_req.wdata : ccb_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      // The interrupt follows the next status and mask, so it rises with the status bit.
      cnt_reg  <= oneshot_pwt_pkg::ZERO16;
      ovf_reg  <= 1'b0;
      stat_reg <= oneshot_pwt_pkg::ZERO2;
      irq      <= 1'b0;
      rd_data  <= oneshot_pwt_pkg::ZERO16;
    end else begin
      cnt_reg  <= cnt_next;
      ovf_reg  <= ovf_next;
      stat_reg <= stat_next;
      irq      <= |(stat_next & mask_next);
      rd_data  <= bus_req.rd ? rd_next : oneshot_pwt_pkg::ZERO16;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      // Armed marks a pending one-shot; the first match sets first_reg.
      // The second match then disarms, so a wrapping counter cannot toggle again.
      timer_output_pin <= 1'b0;
      armed_reg        <= 1'b0;
      first_reg        <= 1'b0;
    end else begin
      timer_output_pin <= out_next;
      if (os_trig) begin
        armed_reg <= 1'b1;
        first_reg <= 1'b0;
      end else if (os_match) begin
        armed_reg <= !first_reg;
        first_reg <= 1'b1;
      end else if (!os_mode) begin
        armed_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Counter and overflow flag.
  a_ovf_wraps: assert property (ovf_set |=> ovf_reg && cnt_reg == oneshot_pwt_pkg::ZERO16)
    else $error("overflow did not set on wrap");

  a_stop_hold: assert property (!running |=> cnt_reg == oneshot_pwt_pkg::ZERO16)
    else $error("stopped counter moved");

  a_free_count: assert property (mode_reg == oneshot_pwt_pkg::MODE_FREE && !cnt_clr |=>
    cnt_reg == 16'($past(cnt_reg) + 16'h0001))
    else $error("free-running counter did not step by one");

  a_ovf_clear: assert property (wr_mode && !bus_req.wdata[oneshot_pwt_pkg::OVF_BIT] &&
    !ovf_set |=> !ovf_reg)
    else $error("overflow flag did not clear");

  a_ovf_keep: assert property (ovf_reg && !wr_mode |=> ovf_reg)
    else $error("overflow flag lost");

  // One-shot sequencing.
  a_trig_clears: assert property (os_trig |=> cnt_reg == oneshot_pwt_pkg::ZERO16 && armed_reg)
    else $error("one-shot trigger did not restart");

  a_os_only: assert property (!os_mode |=> !armed_reg)
    else $error("one-shot armed outside one-shot operation");

  a_os_disarm: assert property (os_match && first_reg && !os_trig |=> !armed_reg)
    else $error("one-shot stayed armed after second match");

  a_os_toggle: assert property (os_mode && n_tog |=> timer_output_pin != $past(timer_output_pin))
    else $error("one-shot output did not toggle");

  a_os_quiet: assert property (os_mode && !armed_reg && !os_trig |=> $stable(timer_output_pin))
    else $error("one-shot output moved while idle");

  a_out_off: assert property (!toe_reg |=> !timer_output_pin)
    else $error("output high while disabled");

  // Compare matches and the pulse generator.
  a_match_a_irq: assert property (match_a |=> stat_reg[oneshot_pwt_pkg::IRQ_A_BIT])
    else $error("match a lost its interrupt");

  a_match_b_irq: assert property (match_b |=> stat_reg[oneshot_pwt_pkg::IRQ_B_BIT])
    else $error("match b lost its interrupt");

  a_ppg_period: assert property (is_ppg && match_a && toe_reg |=> timer_output_pin && cnt_reg == 16'h0000)
    else $error("pulse generator period wrong");

  a_ppg_low: assert property (is_ppg && match_b && !match_a && toe_reg |=> !timer_output_pin)
    else $error("pulse generator did not end its pulse");

  // Captures and interrupts.
  a_cap_b_val: assert property (cap_b |=> ccb_reg == $past(cnt_reg) && stat_reg[1])
    else $error("capture b wrong");

  a_cap_a_val: assert property (cap_a |=> cca_reg == $past(cnt_reg))
    else $error("capture a wrong");

  a_edge_clear: assert property (edge_clr |=> cnt_reg == 16'h0000)
    else $error("edge did not clear counter");

  a_cap_a_irq: assert property (cap_a && !cca_opp |=> stat_reg[oneshot_pwt_pkg::IRQ_A_BIT])
    else $error("capture a lost its interrupt");

  a_opp_quiet: assert property (cap_a && cca_opp && !stat_reg[oneshot_pwt_pkg::IRQ_A_BIT] |=>
    !stat_reg[oneshot_pwt_pkg::IRQ_A_BIT])
    else $error("opposite-edge capture raised interrupt a");

  a_irq_level: assert property (stat_reg == 2'h0 |-> !irq)
    else $error("interrupt high with empty status");

  a_irq_mask: assert property ((stat_reg & mask_reg) != 2'h0 |-> irq)
    else $error("interrupt low with unmasked status");
endmodule
`default_nettype wire

// *** pulse_partner.sv ***
`default_nettype none
// Pin-side stand-in: drives both capture pins and times edges of the timer output.
module pulse_partner (
  input  wire logic mclk,
  input  wire logic timer_output_pin,
  output var logic  capture_input_a,
  output var logic  capture_input_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc = 0;
  int   t_rise = 0;
  int   t_prev = 0;
  int   t_fall = 0;
  logic prev = 1'b0;
  // Pins move only when the bench asks, so no stray trigger reaches input a.
  initial begin
    capture_input_a = 1'b0;
    capture_input_b = 1'b0;
  end
  task automatic drive(input logic sel_b, input logic v);
    if (sel_b) capture_input_b <= v;
    else capture_input_a <= v;
  endtask
  always @(posedge mclk) begin
    cyc  <= cyc + 1;
    prev <= timer_output_pin;
    if (timer_output_pin && !prev) begin
      t_prev <= t_rise;
      t_rise <= cyc;
    end
    if (!timer_output_pin && prev) t_fall <= cyc;
  end
endmodule
`default_nettype wire

// *** tb.sv ***
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      mclk;
  logic                      srst;
  logic                      irq;
  logic                      tpin;
  logic                      cia;
  logic                      cib;
  logic [15:0]               rd_data;
  logic [15:0]               rv;
  logic [15:0]               cap;
  oneshot_pwt_pkg::reg_req_t bus_req;
  int                        err_count = 0;
  int                        n_checks = 0;
  int                        t0, m, n, w, p, hi;
  oneshot_pulse_width_timer i_dut (.mclk(mclk), .srst(srst), .bus_req(bus_req),
    .rd_data(rd_data), .capture_input_a(cia), .capture_input_b(cib),
    .timer_output_pin(tpin), .irq(irq));
  pulse_partner i_part (.mclk(mclk), .timer_output_pin(tpin), .capture_input_a(cia),
    .capture_input_b(cib));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Both tasks start just after a rising edge and leave one idle cycle behind them.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    t0 = i_part.cyc;
    bus_req <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    rv = rd_data;
    @(posedge mclk);
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    test_done();
  end
  initial begin
    bus_req = '0;
    srst = 1'b1;
    void'($urandom(71828));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(oneshot_pwt_pkg::ADDR_MODE);
    `CHK(rv, 16'h0000)
    rd(4'h9);
    `CHK(rv, 16'h0000)
    m = 2 + $urandom % 20;
    n = m + 1 + $urandom % 20;
    wr(oneshot_pwt_pkg::ADDR_CCA, 16'(m));
    wr(oneshot_pwt_pkg::ADDR_CCB, 16'(n));
    wr(oneshot_pwt_pkg::ADDR_IRQMASK, 16'h0003);
    wr(oneshot_pwt_pkg::ADDR_EDGE, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(oneshot_pwt_pkg::ADDR_MODE, (k < 2) ? 16'h0004 : 16'h0008);
      wr(oneshot_pwt_pkg::ADDR_OUTCTL, 16'h0021);
      wr(oneshot_pwt_pkg::ADDR_IRQSTAT, 16'h0003);
      if (k[0]) begin
        i_part.drive(1'b0, 1'b1);
        t0 = i_part.cyc;
      end else wr(oneshot_pwt_pkg::ADDR_OUTCTL, 16'h0061);
      // Wait out the whole pulse before any new trigger.
      repeat (n + 10) @(posedge mclk);
      `CHK(i_part.t_fall - i_part.t_rise, n - m)
      `CHK(i_part.t_rise > t0, 1'b1)
      // M + 1 clocks to the pin, plus the one the partner takes to see it.
      if (!k[0]) `CHK(i_part.t_rise - t0, m + 2)
      `CHK(irq, 1'b1)
      rd(oneshot_pwt_pkg::ADDR_IRQSTAT);
      `CHK(rv, 16'h0003)
      i_part.drive(1'b0, 1'b0);
    end
    wr(oneshot_pwt_pkg::ADDR_IRQMASK, 16'h0000);
    rd(oneshot_pwt_pkg::ADDR_IRQSTAT);
    `CHK(irq, 1'b0)
    `CHK(rv, 16'h0003)
    wr(oneshot_pwt_pkg::ADDR_IRQSTAT, 16'h0003);
    wr(oneshot_pwt_pkg::ADDR_IRQMASK, 16'h0003);
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0000);
    wr(oneshot_pwt_pkg::ADDR_OUTCTL, 16'h0061);
    repeat (n + 10) @(posedge mclk);
    `CHK(i_part.t_rise < t0, 1'b1)
    p = $urandom % m;
    wr(oneshot_pwt_pkg::ADDR_CCB, 16'(p));
    wr(oneshot_pwt_pkg::ADDR_OUTCTL, 16'h0001);
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h000c);
    repeat (3 * m + 12) @(posedge mclk);
    `CHK(i_part.t_rise - i_part.t_prev, m + 1)
    hi = i_part.t_fall - ((i_part.t_fall > i_part.t_rise) ? i_part.t_rise : i_part.t_prev);
    `CHK(hi, p + 1)
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0000);
    wr(oneshot_pwt_pkg::ADDR_OUTCTL, 16'h0000);
    wr(oneshot_pwt_pkg::ADDR_EDGE, 16'h000f);
    wr(oneshot_pwt_pkg::ADDR_CAPCTL, 16'h0005);
    // The count clock stays mclk; input a never clocks the counter.
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0004);
    wr(oneshot_pwt_pkg::ADDR_IRQSTAT, 16'h0003);
    w = 5 + $urandom % 50;
    i_part.drive(1'b0, 1'b1);
    repeat (w) @(posedge mclk);
    i_part.drive(1'b1, 1'b1);
    repeat (8) @(posedge mclk);
    rd(oneshot_pwt_pkg::ADDR_CCB);
    cap = rv;
    rd(oneshot_pwt_pkg::ADDR_CCA);
    `CHK(16'(rv - cap), 16'(w))
    rd(oneshot_pwt_pkg::ADDR_IRQSTAT);
    `CHK(rv, 16'h0003)
    i_part.drive(1'b0, 1'b0);
    repeat (8) @(posedge mclk);
    wr(oneshot_pwt_pkg::ADDR_CAPCTL, 16'h0007);
    wr(oneshot_pwt_pkg::ADDR_EDGE, 16'h0001);
    wr(oneshot_pwt_pkg::ADDR_IRQSTAT, 16'h0003);
    i_part.drive(1'b0, 1'b1);
    repeat (w) @(posedge mclk);
    i_part.drive(1'b0, 1'b0);
    repeat (8) @(posedge mclk);
    rd(oneshot_pwt_pkg::ADDR_CCB);
    cap = rv;
    rd(oneshot_pwt_pkg::ADDR_CCA);
    `CHK(16'(rv - cap), 16'(w))
    rd(oneshot_pwt_pkg::ADDR_IRQSTAT);
    `CHK(rv, 16'h0002)
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0008);
    p = w + 5 + $urandom % 50;
    i_part.drive(1'b0, 1'b1);
    repeat (w) @(posedge mclk);
    i_part.drive(1'b0, 1'b0);
    repeat (p - w) @(posedge mclk);
    i_part.drive(1'b0, 1'b1);
    repeat (8) @(posedge mclk);
    rd(oneshot_pwt_pkg::ADDR_CCA);
    cap = rv;
    rd(oneshot_pwt_pkg::ADDR_CCB);
    `CHK(16'(rv - cap), 16'(p - w))
    rd(oneshot_pwt_pkg::ADDR_COUNT);
    `CHK(rv < 16'h0020, 1'b1)
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0000);
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0004);
    repeat (65550) @(posedge mclk);
    rd(oneshot_pwt_pkg::ADDR_MODE);
    `CHK(rv[0], 1'b1)
    rd(oneshot_pwt_pkg::ADDR_COUNT);
    `CHK(rv < 16'h0040, 1'b1)
    wr(oneshot_pwt_pkg::ADDR_MODE, 16'h0004);
    rd(oneshot_pwt_pkg::ADDR_MODE);
    `CHK(rv[0], 1'b0)
    test_done();
  end
endmodule
`default_nettype wire
